/* File: bra_pkg.sv */
// Purpose: shared constants and types for the bus region access checker
// Assumes: 32-bit system bus addresses, one system clock
// Notes: descriptor words are start, end, access control, control
package bra_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_REGIONS = 16;
  localparam int NUM_PORTS = 2;
  localparam int DESC_BITS = 128;
  // address compare drops the low bits: 32-byte granule
  localparam int GRAN_LSB = 5;

  // ----------------------------------------------------------------
  // descriptor word selects
  // ----------------------------------------------------------------
  localparam logic [1:0] WORD_START = 2'h0;
  localparam logic [1:0] WORD_END = 2'h1;
  localparam logic [1:0] WORD_ACW = 2'h2;
  localparam logic [1:0] WORD_CTRL = 2'h3;

  // ----------------------------------------------------------------
  // access control word fields
  // ----------------------------------------------------------------
  localparam int ACW_SUP_LSB = 0;
  localparam int ACW_USR_LSB = 3;
  localparam int ACW_DMA_LSB = 6;
  localparam int ACW_NET_LSB = 8;
  localparam int PERM_R = 0;
  localparam int PERM_W = 1;
  localparam int PERM_X = 2;
  localparam int CTRL_VALID_BIT = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MST_CORE, MST_DMA, MST_NET} bra_master_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] acw;
    logic [31:0] end_addr;
    logic [31:0] start_addr;
  } bra_desc_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    bra_master_t master;
    logic write;
    logic fetch;
    logic supervisor;
  } bra_req_t;

  typedef struct packed {
    logic ok;
    logic err;
  } bra_rsp_t;

  typedef struct packed {
    logic wr;
    logic alt;
    logic [3:0] idx;
    logic [1:0] word;
    logic [31:0] data;
  } bra_prog_t;

  typedef struct packed {
    bra_desc_t [NUM_REGIONS-1:0] desc;
    logic enable;
    bra_rsp_t [NUM_PORTS-1:0] rsp;
    logic err_seen;
    logic err_port;
    logic [31:0] err_addr;
    bra_master_t err_master;
    logic err_write;
    logic err_fetch;
    logic [31:0] rd_data;
  } bra_state_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam bra_state_t STATE_RESET = '0;

endpackage

/* File: bra_region_eval.sv */
// Purpose: parallel match of one bus request against all region descriptors
// Assumes: descriptors are stable flops in the caller
// Notes: purely combinational; the caller registers the verdict
`timescale 1ns/1ps
module bra_region_eval (
  input bra_pkg::bra_desc_t [bra_pkg::NUM_REGIONS-1:0] i_desc,
  input bra_pkg::bra_req_t i_req,
  output logic o_grant,
  output logic [bra_pkg::NUM_REGIONS-1:0] o_hit
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input bra_pkg::bra_desc_t d, input logic [31:0] a);
    in_range = (a[31:bra_pkg::GRAN_LSB] >= d.start_addr[31:bra_pkg::GRAN_LSB]) &&
               (a[31:bra_pkg::GRAN_LSB] <= d.end_addr[31:bra_pkg::GRAN_LSB]);
  endfunction

  function automatic logic has_right(input logic [31:0] acw, input bra_pkg::bra_req_t q);
    logic [2:0] need;
    logic [2:0] have;
    need = '0;
    have = '0;
    // only the core fetches with an execute right; other masters read
    need[bra_pkg::PERM_X] = q.fetch && (q.master == bra_pkg::MST_CORE);
    need[bra_pkg::PERM_W] = q.write;
    need[bra_pkg::PERM_R] = !q.write && !need[bra_pkg::PERM_X];
    case (q.master)
      bra_pkg::MST_CORE:
      begin
        have = q.supervisor ? acw[bra_pkg::ACW_SUP_LSB +: 3] : acw[bra_pkg::ACW_USR_LSB +: 3];
      end
      bra_pkg::MST_DMA:
      begin
        have = {1'b0, acw[bra_pkg::ACW_DMA_LSB +: 2]};
      end
      bra_pkg::MST_NET:
      begin
        have = {1'b0, acw[bra_pkg::ACW_NET_LSB +: 2]};
      end
      default:
      begin
        have = '0;
      end
    endcase
    has_right = |(need & have);
  endfunction

  // ----------------------------------------------------------------
  // match
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int r = 0; r < bra_pkg::NUM_REGIONS; r++)
    begin
      o_hit[r] = i_desc[r].ctrl[bra_pkg::CTRL_VALID_BIT] && in_range(i_desc[r], i_req.addr) &&
                 has_right(i_desc[r].acw, i_req);
    end
    // any granting region wins over the others
    o_grant = |o_hit;
  end

endmodule

/* File: bra_region_checker.sv */
// Purpose: region access checker watching two crossbar slave ports
// Assumes: requests and programming come from logic on i_sys_clk
// Notes: verdict is registered, one cycle after the request
//
// Behaviour
// - every transfer is checked in parallel; permitted ones complete normally
// - unmapped or under-privileged transfers end with a protection error
// - sixteen descriptors of 128 bits each hold ranges and rights
// - start and end bounds compare at 32-byte granules, up to 4 GB
// - after reset checking is off and every transfer passes
// - core gets read, write, execute rights, separate for supervisor and user
// - dma and network masters get read and write rights only
// - hardware clears the valid bit on start, end and access control word writes so half-written descriptors are unused
// - an alternate view rewrites only the access control word
// - with overlapping regions, any granting region allows the access
// - both the sram port and peripheral bridge port are checked
`timescale 1ns/1ps
module bra_region_checker (
  input logic i_sys_clk,
  input logic i_rst,
  input logic i_chk_enable,
  input bra_pkg::bra_req_t [bra_pkg::NUM_PORTS-1:0] i_req,
  input bra_pkg::bra_prog_t i_prog,
  input logic [3:0] i_rd_idx,
  input logic [1:0] i_rd_word,
  input logic i_err_clr,
  output bra_pkg::bra_rsp_t [bra_pkg::NUM_PORTS-1:0] o_rsp,
  output logic o_chk_valid,
  output logic [bra_pkg::NUM_REGIONS-1:0] o_desc_valid,
  output logic [31:0] o_rd_data,
  output logic o_err_seen,
  output logic o_err_port,
  output logic [31:0] o_err_addr,
  output bra_pkg::bra_master_t o_err_master,
  output logic o_err_write,
  output logic o_err_fetch
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bra_pkg::bra_state_t st_r;
  bra_pkg::bra_state_t st_nxt;
  logic [bra_pkg::NUM_PORTS-1:0] grant;
  logic [bra_pkg::NUM_PORTS-1:0] err_now;

  // ----------------------------------------------------------------
  // per-port evaluation
  // ----------------------------------------------------------------
  // port 0 is the sram port, port 1 the peripheral bridge port
  for (genvar p = 0; p < bra_pkg::NUM_PORTS; p++)
  begin : g_port
    bra_region_eval u_eval (
      .i_desc(st_r.desc),
      .i_req(i_req[p]),
      .o_grant(grant[p]),
      .o_hit()
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.enable = i_chk_enable;

    // descriptor programming
    if (i_prog.wr)
    begin
      if (i_prog.alt)
      begin
        // rights only: bounds and valid bit untouched
        st_nxt.desc[i_prog.idx].acw = i_prog.data;
      end
      else
      begin
        unique case (i_prog.word)
          bra_pkg::WORD_START:
          begin
            st_nxt.desc[i_prog.idx].start_addr = i_prog.data;
            st_nxt.desc[i_prog.idx].ctrl[bra_pkg::CTRL_VALID_BIT] = 1'b0;
          end
          bra_pkg::WORD_END:
          begin
            st_nxt.desc[i_prog.idx].end_addr = i_prog.data;
            st_nxt.desc[i_prog.idx].ctrl[bra_pkg::CTRL_VALID_BIT] = 1'b0;
          end
          bra_pkg::WORD_ACW:
          begin
            st_nxt.desc[i_prog.idx].acw = i_prog.data;
            st_nxt.desc[i_prog.idx].ctrl[bra_pkg::CTRL_VALID_BIT] = 1'b0;
          end
          bra_pkg::WORD_CTRL:
          begin
            // the last word written makes the descriptor usable
            st_nxt.desc[i_prog.idx].ctrl = i_prog.data;
          end
        endcase
      end
    end

    // verdicts: decided on current descriptors, so a write takes effect next cycle
    for (int p = 0; p < bra_pkg::NUM_PORTS; p++)
    begin
      err_now[p] = i_req[p].valid && st_r.enable && !grant[p];
      st_nxt.rsp[p].err = err_now[p];
      st_nxt.rsp[p].ok = i_req[p].valid && (!st_r.enable || grant[p]);
    end

    // error capture: first error held until cleared; a new error beats the clear
    if (i_err_clr)
    begin
      st_nxt.err_seen = 1'b0;
    end
    if ((|err_now) && (!st_r.err_seen || i_err_clr))
    begin
      st_nxt.err_seen = 1'b1;
      // descending loop lets the sram port win a tie
      for (int p = bra_pkg::NUM_PORTS - 1; p >= 0; p--)
      begin
        if (err_now[p])
        begin
          st_nxt.err_port = 1'(p);
          st_nxt.err_addr = i_req[p].addr;
          st_nxt.err_master = i_req[p].master;
          st_nxt.err_write = i_req[p].write;
          st_nxt.err_fetch = i_req[p].fetch;
        end
      end
    end

    // descriptor readback
    unique case (i_rd_word)
      bra_pkg::WORD_START:
      begin
        st_nxt.rd_data = st_r.desc[i_rd_idx].start_addr;
      end
      bra_pkg::WORD_END:
      begin
        st_nxt.rd_data = st_r.desc[i_rd_idx].end_addr;
      end
      bra_pkg::WORD_ACW:
      begin
        st_nxt.rd_data = st_r.desc[i_rd_idx].acw;
      end
      bra_pkg::WORD_CTRL:
      begin
        st_nxt.rd_data = st_r.desc[i_rd_idx].ctrl;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= bra_pkg::STATE_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rsp = st_r.rsp;
  assign o_chk_valid = st_r.enable;
  assign o_rd_data = st_r.rd_data;
  assign o_err_seen = st_r.err_seen;
  assign o_err_port = st_r.err_port;
  assign o_err_addr = st_r.err_addr;
  assign o_err_master = st_r.err_master;
  assign o_err_write = st_r.err_write;
  assign o_err_fetch = st_r.err_fetch;

  always_comb
  begin
    for (int r = 0; r < bra_pkg::NUM_REGIONS; r++)
    begin
      o_desc_valid[r] = st_r.desc[r].ctrl[bra_pkg::CTRL_VALID_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  for (genvar p = 0; p < bra_pkg::NUM_PORTS; p++)
  begin : g_chk
    grant_ok_a: assert property (
      (i_req[p].valid && st_r.enable && grant[p]) |=> (o_rsp[p].ok && !o_rsp[p].err))
      else $error("permitted transfer not completed");
    deny_err_a: assert property (
      (i_req[p].valid && st_r.enable && !grant[p]) |=> (o_rsp[p].err && !o_rsp[p].ok))
      else $error("refused transfer not ended with error");
    open_pass_a: assert property (
      (i_req[p].valid && !st_r.enable) |=> (o_rsp[p].ok && !o_rsp[p].err))
      else $error("transfer blocked while checker is off");
    idle_quiet_a: assert property (
      !i_req[p].valid |=> (!o_rsp[p].ok && !o_rsp[p].err))
      else $error("answer without request");
    err_needs_on_a: assert property (
      o_rsp[p].err |-> $past(o_chk_valid))
      else $error("error while checker was off");
    empty_deny_a: assert property (
      (i_req[p].valid && st_r.enable && (o_desc_valid == '0)) |=> (o_rsp[p].err && !o_rsp[p].ok))
      else $error("transfer passed with no valid region");
  end

  bound_clr_a: assert property (
    (i_prog.wr && !i_prog.alt && (i_prog.word != bra_pkg::WORD_CTRL))
      |=> !o_desc_valid[$past(i_prog.idx)])
    else $error("bound write left descriptor valid");
  ctrl_valid_a: assert property (
    (i_prog.wr && !i_prog.alt && (i_prog.word == bra_pkg::WORD_CTRL))
      |=> (o_desc_valid[$past(i_prog.idx)] == $past(i_prog.data[bra_pkg::CTRL_VALID_BIT])))
    else $error("control write did not set valid bit");
  alt_keep_a: assert property (
    (i_prog.wr && i_prog.alt) |=> $stable(o_desc_valid))
    else $error("alternate view changed valid bits");
  reset_open_a: assert property (
    $rose(o_chk_valid) |-> $past(i_chk_enable))
    else $error("checker enabled without request");
  err_hold_a: assert property (
    (o_err_seen && !i_err_clr) |=> (o_err_seen && $stable(o_err_addr)))
    else $error("captured error lost");

  // ----------------------------------------------------------------
  // checks: error capture and enable
  // ----------------------------------------------------------------
  err_keep_a: assert property (
    (o_err_seen && !i_err_clr)
      |=> ($stable(o_err_port) && $stable(o_err_master) && $stable(o_err_write) && $stable(o_err_fetch)))
    else $error("captured error details changed");
  clr_drop_a: assert property (
    (i_err_clr && !(|err_now))
      |=> !o_err_seen)
    else $error("error flag not cleared");
  err_first_a: assert property (
    (i_req[0].valid && st_r.enable && !grant[0] && (!o_err_seen || i_err_clr))
      |=> (o_err_seen && !o_err_port && (o_err_addr == $past(i_req[0].addr))
           && (o_err_master == $past(i_req[0].master)) && (o_err_fetch == $past(i_req[0].fetch))))
    else $error("sram port error not captured");
  err_second_a: assert property (
    (i_req[1].valid && st_r.enable && !grant[1] && !(i_req[0].valid && st_r.enable && !grant[0])
      && (!o_err_seen || i_err_clr))
      |=> (o_err_seen && o_err_port && (o_err_addr == $past(i_req[1].addr))
           && (o_err_write == $past(i_req[1].write))))
    else $error("bridge port error not captured");
  en_follow_a: assert property (
    !i_rst
      |=> (o_chk_valid == $past(i_chk_enable)))
    else $error("checker state does not follow enable");

  // ----------------------------------------------------------------
  // checks: descriptor storage and readback
  // ----------------------------------------------------------------
  // stored words are checked directly, so a lost write shows even when no transfer uses it
  desc_keep_a: assert property (
    !i_prog.wr
      |=> $stable(o_desc_valid))
    else $error("valid bit changed without a write");
  start_store_a: assert property (
    (i_prog.wr && !i_prog.alt && (i_prog.word == bra_pkg::WORD_START))
      |=> (st_r.desc[$past(i_prog.idx)].start_addr == $past(i_prog.data)))
    else $error("start address not stored");
  end_store_a: assert property (
    (i_prog.wr && !i_prog.alt && (i_prog.word == bra_pkg::WORD_END))
      |=> (st_r.desc[$past(i_prog.idx)].end_addr == $past(i_prog.data)))
    else $error("end address not stored");
  acw_store_a: assert property (
    (i_prog.wr && (i_prog.alt || (i_prog.word == bra_pkg::WORD_ACW)))
      |=> (st_r.desc[$past(i_prog.idx)].acw == $past(i_prog.data)))
    else $error("access control word not stored");
  ctrl_store_a: assert property (
    (i_prog.wr && !i_prog.alt && (i_prog.word == bra_pkg::WORD_CTRL))
      |=> (st_r.desc[$past(i_prog.idx)].ctrl == $past(i_prog.data)))
    else $error("control word not stored");
  alt_bounds_a: assert property (
    (i_prog.wr && i_prog.alt)
      |=> ((st_r.desc[$past(i_prog.idx)].start_addr == $past(st_r.desc[i_prog.idx].start_addr))
           && (st_r.desc[$past(i_prog.idx)].end_addr == $past(st_r.desc[i_prog.idx].end_addr))))
    else $error("alternate view changed the bounds");
  rd_start_a: assert property (
    (i_rd_word == bra_pkg::WORD_START)
      |=> (o_rd_data == $past(st_r.desc[i_rd_idx].start_addr)))
    else $error("start readback wrong");
  rd_end_a: assert property (
    (i_rd_word == bra_pkg::WORD_END)
      |=> (o_rd_data == $past(st_r.desc[i_rd_idx].end_addr)))
    else $error("end readback wrong");
  rd_acw_a: assert property (
    (i_rd_word == bra_pkg::WORD_ACW)
      |=> (o_rd_data == $past(st_r.desc[i_rd_idx].acw)))
    else $error("access control readback wrong");
  rd_ctrl_a: assert property (
    (i_rd_word == bra_pkg::WORD_CTRL)
      |=> (o_rd_data == $past(st_r.desc[i_rd_idx].ctrl)))
    else $error("control readback wrong");

endmodule

/* File: bra_bus_model.sv */
// Purpose: bus master side of both crossbar slave ports
// Assumes: inputs change at the rising edge of i_sys_clk, outputs at the falling edge
// Notes: released address lines are inverted so stale values never match
`timescale 1ns/1ps
module bra_bus_model (
  input bra_pkg::bra_rsp_t [bra_pkg::NUM_PORTS-1:0] i_rsp,
  input logic i_sys_clk,
  output bra_pkg::bra_req_t [bra_pkg::NUM_PORTS-1:0] o_req
);
  initial o_req = '0;
  // one transfer per port; the verdict is read at the falling edge half a cycle after the taking edge
  task automatic xfer(input bra_pkg::bra_req_t r0, input bra_pkg::bra_req_t r1,
    output bra_pkg::bra_rsp_t s0, output bra_pkg::bra_rsp_t s1);
    @(negedge i_sys_clk);
    o_req[0] = r0;
    o_req[1] = r1;
    @(negedge i_sys_clk);
    o_req[0].valid = 1'b0;
    o_req[1].valid = 1'b0;
    o_req[0].addr = ~r0.addr;
    o_req[1].addr = ~r1.addr;
    s0 = i_rsp[0];
    s1 = i_rsp[1];
  endtask
endmodule

/* File: bra_region_checker_test.sv */
// Purpose: self-checking bench for the region access checker
// Assumes: 40 MHz clock, inputs driven at the falling edge
// Notes: region 0 is a 32-byte window, region 15 spans the whole space
`timescale 1ns/1ps
module bra_region_checker_test;
  logic i_sys_clk;
  logic i_rst;
  logic chk_en;
  bra_pkg::bra_req_t [1:0] req;
  bra_pkg::bra_prog_t prog;
  logic [3:0] rd_idx;
  logic [1:0] rd_word;
  logic err_clr;
  bra_pkg::bra_rsp_t [1:0] rsp;
  logic chk_valid;
  logic [15:0] desc_valid;
  logic [31:0] rd_data;
  logic err_seen;
  logic err_port;
  logic [31:0] err_addr;
  bra_pkg::bra_master_t err_master;
  logic err_write;
  logic err_fetch;
  int errors;
  int n_checks;
  localparam logic [31:0] BASE = 32'h1000_0020;

  bra_region_checker i_bra_region_checker (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_chk_enable(chk_en),
    .i_req(req), .i_prog(prog), .i_rd_idx(rd_idx), .i_rd_word(rd_word), .i_err_clr(err_clr),
    .o_rsp(rsp), .o_chk_valid(chk_valid), .o_desc_valid(desc_valid), .o_rd_data(rd_data),
    .o_err_seen(err_seen), .o_err_port(err_port), .o_err_addr(err_addr), .o_err_master(err_master),
    .o_err_write(err_write), .o_err_fetch(err_fetch));
  bra_bus_model i_bra_bus_model (.i_rsp(rsp), .i_sys_clk(i_sys_clk), .o_req(req));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input bra_pkg::bra_rsp_t got, input logic ok);
    chk({30'h0, got}, {30'h0, ok, ~ok});
  endtask

  // kind 0-2 core supervisor r/w/x, 3-5 core user r/w/x, 6-7 dma r/w, 8-9 net r/w
  function automatic bra_pkg::bra_req_t mk(input int k, input logic [31:0] a);
    bra_pkg::bra_req_t r;
    int p;
    p = (k < 6) ? k % 3 : k % 2;
    r.valid = 1'b1;
    r.addr = a;
    r.master = (k < 6) ? bra_pkg::MST_CORE : (k < 8) ? bra_pkg::MST_DMA : bra_pkg::MST_NET;
    r.write = (p == 1);
    r.fetch = (p == 2);
    r.supervisor = (k < 3);
    return r;
  endfunction

  task automatic one(input int p, input bra_pkg::bra_req_t r, input logic ok);
    bra_pkg::bra_rsp_t s0;
    bra_pkg::bra_rsp_t s1;
    if (p == 0)
      i_bra_bus_model.xfer(r, '0, s0, s1);
    else
      i_bra_bus_model.xfer('0, r, s0, s1);
    chk_rsp(p == 0 ? s0 : s1, ok);
    chk({30'h0, p == 0 ? s1 : s0}, 32'h0);
  endtask

  task automatic wr(input logic [3:0] i, input logic [1:0] w, input logic [31:0] d, input logic alt);
    @(negedge i_sys_clk);
    prog = '{wr: 1'b1, alt: alt, idx: i, word: w, data: d};
    @(negedge i_sys_clk);
    prog.wr = 1'b0;
    @(negedge i_sys_clk);
  endtask

  task automatic region(input logic [3:0] i, input logic [31:0] s, input logic [31:0] e, input logic [31:0] a);
    wr(i, bra_pkg::WORD_START, s, 1'b0);
    wr(i, bra_pkg::WORD_END, e, 1'b0);
    wr(i, bra_pkg::WORD_ACW, a, 1'b0);
    wr(i, bra_pkg::WORD_CTRL, 32'h1, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({31'h0, chk_valid}, 32'h0);
    chk({16'h0, desc_valid}, 32'h0);
    one(0, mk(1, 32'h0), 1'b1);
    one(1, mk(9, 32'hFFFF_FFE0), 1'b1);
  endtask

  task automatic t_unmapped;
    @(negedge i_sys_clk);
    chk_en = 1'b1;
    @(negedge i_sys_clk);
    chk({31'h0, chk_valid}, 32'h1);
    one(0, mk(2, 32'h2000_0000), 1'b0);
    chk({err_seen, err_port, err_addr[29:0]}, 32'hA000_0000);
    chk({29'h0, err_fetch, err_master}, {29'h0, 1'b1, bra_pkg::MST_CORE});
    err_clr = 1'b1;
    @(negedge i_sys_clk);
    err_clr = 1'b0;
    chk({31'h0, err_seen}, 32'h0);
    one(1, mk(7, 32'h3000_0040), 1'b0);
    chk({27'h0, err_fetch, err_port, err_write, err_master}, {27'h0, 3'b011, bra_pkg::MST_DMA});
    // clear and new error in one cycle: the new error must be captured
    fork
      one(0, mk(3, 32'h0500_0000), 1'b0);
      begin
        @(negedge i_sys_clk);
        err_clr = 1'b1;
        @(negedge i_sys_clk);
        err_clr = 1'b0;
      end
    join
    chk({err_seen, err_port, err_addr[29:0]}, 32'h8500_0000);
    chk({27'h0, err_fetch, err_port, err_write, err_master}, {27'h0, 3'b000, bra_pkg::MST_CORE});
  endtask

  task automatic t_bounds;
    region(4'h0, BASE, BASE + 32'h1F, 32'h3FF);
    chk({16'h0, desc_valid}, 32'h1);
    one(0, mk(0, BASE - 32'h1), 1'b0);
    one(1, mk(0, BASE), 1'b1);
    one(0, mk(0, BASE + 32'h1F), 1'b1);
    one(1, mk(0, BASE + 32'h20), 1'b0);
    rd_idx = 4'h0;
    rd_word = bra_pkg::WORD_END;
    @(negedge i_sys_clk);
    chk(rd_data, BASE + 32'h1F);
  endtask

  task automatic t_rights;
    bra_pkg::bra_req_t r;
    for (int b = 0; b < 10; b++)
    begin
      wr(4'h0, bra_pkg::WORD_START, 32'h1 << b, 1'b1);
      chk({16'h0, desc_valid}, 32'h1);
      for (int k = 0; k < 10; k++)
        one(k % 2, mk(k, BASE), k == b);
      r = mk(6, BASE);
      r.fetch = 1'b1;
      one(1, r, b == 6);
    end
    wr(4'h0, bra_pkg::WORD_START, 32'h3FF, 1'b1);
  endtask

  task automatic t_valid;
    wr(4'h0, bra_pkg::WORD_START, BASE, 1'b0);
    chk({16'h0, desc_valid}, 32'h0);
    one(0, mk(0, BASE), 1'b0);
    wr(4'h0, bra_pkg::WORD_CTRL, 32'h1, 1'b0);
    one(0, mk(0, BASE), 1'b1);
  endtask

  task automatic t_overlap;
    bra_pkg::bra_rsp_t s0;
    bra_pkg::bra_rsp_t s1;
    region(4'hF, 32'h0, 32'hFFFF_FFFF, 32'h1 << bra_pkg::ACW_DMA_LSB);
    chk({16'h0, desc_valid}, 32'h8001);
    i_bra_bus_model.xfer(mk(7, BASE), mk(6, 32'hFFFF_FFE0), s0, s1);
    chk_rsp(s0, 1'b1);
    chk_rsp(s1, 1'b1);
    i_bra_bus_model.xfer(mk(4, 32'hFFFF_FFE0), mk(8, BASE), s0, s1);
    chk_rsp(s0, 1'b0);
    chk_rsp(s1, 1'b1);
  endtask

  task automatic t_rerun;
    @(negedge i_sys_clk);
    chk_en = 1'b0;
    i_rst = 1'b1;
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk({16'h0, desc_valid}, 32'h0);
    chk({31'h0, err_seen}, 32'h0);
    one(1, mk(4, BASE), 1'b1);
    chk({31'h0, chk_valid}, 32'h0);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #150000;
    errors++;
    end_of_test();
  end

  initial
  begin
    errors = 0;
    n_checks = 0;
    i_rst = 1'b1;
    chk_en = 1'b0;
    prog = '0;
    rd_idx = 4'h0;
    rd_word = 2'h0;
    err_clr = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'b0;
    t_reset();
    t_unmapped();
    t_bounds();
    t_rights();
    t_valid();
    t_overlap();
    t_rerun();
    end_of_test();
  end
endmodule
